// *** hdl/wra_offset_mem.sv ***
// Offset store: five signed 32-bit words, registered read port
// Assumes one clock, reset already synchronised by the caller
`timescale 1ns/1ps
`include "wra_regs.svh"

module wra_offset_mem #(
   parameter int DEPTH = 5,
   parameter int AW    = 3
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_nrst,
   // Write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [31:0]   i_wdata,
   // Read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [31:0]   o_rdata
);

   logic [31:0] mem_q [DEPTH];

   // Words cleared at reset, written on strobe, read into a register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= `WRA_OFFSET_RST; // [RULE3]
         end
         o_rdata <= `WRA_OFFSET_RST;
      end else begin
         if (i_we && (int'(i_waddr) < DEPTH)) begin
            mem_q[i_waddr] <= i_wdata;
         end
         if (int'(i_raddr) < DEPTH) begin
            o_rdata <= mem_q[i_raddr];
         end else begin
            o_rdata <= `WRA_OFFSET_RST;
         end
      end
   end

endmodule : wra_offset_mem

// *** hdl/wra_top.sv ***
// Windowed access from a fieldbus object port into controller registers
// Assumes one 40 MHz clock; object requests synchronous, one at a time
//
// Overview of operation
// [RULE1] Register number is bank subindex plus that bank's offset value.
// [RULE2] Offsets one to three serve integer banks, four and five doubles.
// [RULE3] Five signed 32-bit offsets, read/write, reset zero; count reads five.
// [RULE4] Bank n resolves its register with offset entry n.
// [RULE5] Each bank has entries one to sixteen; its count reads sixteen.
// [RULE6] Banks one to three carry signed 32-bit integers.
// [RULE7] Banks four and five carry 64-bit doubles.
// [RULE8] Bank reads and writes both reach the resolved controller register.
// [RULE9] Offsets widen reach beyond thirty-six thousand controller registers.
// [RULE10] Required receive image size reported read-only.
// [RULE11] Required transmit image size reported read-only.
// [RULE12] Maximum sizes both 1024, size object count reads four.
// [RULE13] Master should set its manager lengths to the required sizes.
// [RULE14] Each bank access reads the offset current at that moment.
//
// Request timing, counted in rising edges after the taking edge c0:
//   immediate answers (counts, sizes, offset writes, refusals) at c1;
//   offset reads at c2, the stored word needs one edge to come out;
//   bank accesses raise the controller request at c2 and answer one
//   edge after the controller's acknowledge is sampled.
// o_busy covers every multi-edge request and falls with o_ack, so a
// new request may stand in the same cycle as the answer.
// A request that arrives while o_busy is high is dropped silently;
// the master must wait for the answer before it asks again.
//
// Offset lookups start in the taking cycle, so an offset written by
// the request just before is already in the store: the store takes
// the write on c0 and the bank lookup reads it on the next take.
// The register number wraps at 32 bits: a negative offset larger than
// the subindex gives a number near the top of the space, which the
// controller is expected to refuse on its own side.
//
// Integer banks move the low word only and sign-extend it both ways;
// double banks move all 64 bits untouched, no conversion is done here.
// Write answers leave o_rdata as it was, except refused writes to
// subindex zero of the offset and bank objects, which load the count;
// otherwise a master that reads the answer word after a write sees
// the last read value.
// Required image sizes are sampled live on the taking edge.
// Entry counts answer on subindex zero of every object and refuse
// writes; subindexes past the count answer with o_err and no effect.
// The state struct keeps the reset synchroniser too: its two bits
// are the only part that runs while the internal reset is held.
`timescale 1ns/1ps
`include "wra_regs.svh"

module wra_top
   import wra_pkg::*;
#(
   parameter int REG_NUM_W = 32
) (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_nrst,
   // Object request from the fieldbus side
   input  wire logic                 i_req,
   input  wire logic                 i_wr,
   input  wire logic [15:0]          i_index,
   input  wire logic [7:0]           i_sub,
   input  wire logic [63:0]          i_wdata,
   // Object answer
   output logic                      o_busy,
   output logic                      o_ack,
   output logic                      o_err,
   output logic [63:0]               o_rdata,
   // Controller register port
   output logic                      o_ctl_req,
   output logic                      o_ctl_wr,
   output logic                      o_ctl_dbl,
   output logic [REG_NUM_W-1:0]      o_ctl_regnum,
   output logic [63:0]               o_ctl_wdata,
   input  wire logic                 i_ctl_ack,
   input  wire logic [63:0]          i_ctl_rdata,
   // Image sizes from the mapping logic
   input  wire logic [31:0]          i_rx_req_size,
   input  wire logic [31:0]          i_tx_req_size
);

   wra_state_s_t q;
   wra_state_s_t d;
   logic         nrst_int;
   logic         mem_we;
   logic [2:0]   mem_waddr;
   logic [2:0]   mem_raddr;
   logic [31:0]  mem_rdata;

   // Bank number 1..5 for a bank index, zero otherwise
   function automatic logic [2:0] bank_of(input logic [15:0] idx);
      logic [15:0] rel;
      rel = idx - `WRA_IDX_BANK1;
      if (idx >= `WRA_IDX_BANK1 && idx <= `WRA_IDX_BANK5) begin
         bank_of = rel[2:0] + 3'h1;
      end else begin
         bank_of = 3'h0;
      end
   endfunction : bank_of

   // Sign-extend a 32-bit word to the answer width
   function automatic logic [63:0] sext(input logic [31:0] v);
      sext = {{32{v[31]}}, v};
   endfunction : sext

   // Reset release through two flip-flops
   assign nrst_int = q.rst_sync[1];

   // Offset store
   wra_offset_mem #(
      .DEPTH (5),
      .AW    (3)
   ) u_offset_mem (
      .i_clk   (i_clk),
      .i_nrst  (nrst_int),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (i_wdata[31:0]),
      .i_raddr (mem_raddr),
      .o_rdata (mem_rdata)
   );

   // Memory strobes: offset writes and offset lookups in idle
   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = i_sub[2:0] - 3'h1;
      mem_raddr = 3'h0;
      if (q.st == WRA_IDLE && i_req) begin
         if (i_index == `WRA_IDX_OFFSET) begin
            mem_raddr = i_sub[2:0] - 3'h1;
            mem_we    = i_wr && i_sub != `WRA_SUB_COUNT
                        && i_sub <= `WRA_OFFSET_CNT; // [RULE3]
         end else if (bank_of(i_index) != 3'h0) begin
            mem_raddr = bank_of(i_index) - 3'h1; // [RULE4] [RULE14]
         end
      end
   end

   // Next-state logic
   always_comb begin
      logic [2:0]  bk;
      logic [31:0] sum;
      bk  = bank_of(i_index);
      sum = 32'(q.sub) + mem_rdata;
      d   = q;
      d.rst_sync = {q.rst_sync[0], 1'b1};
      d.ack = 1'b0;
      d.err = 1'b0;
      case (q.st)
         // Idle: decode the object index and answer at once where the
         // value is known, else start the offset or bank sequence
         WRA_IDLE: begin
            if (i_req) begin
               d.wr    = i_wr;
               d.sub   = i_sub;
               d.wdata = i_wdata;
               d.bank  = bk;
               d.ack   = 1'b1;
               if (i_index == `WRA_IDX_OFFSET) begin
                  if (i_sub == `WRA_SUB_COUNT) begin
                     d.err   = i_wr;
                     d.rdata = 64'(`WRA_OFFSET_CNT); // [RULE3]
                  end else if (i_sub > `WRA_OFFSET_CNT) begin
                     d.err = 1'b1;
                  end else if (!i_wr) begin
                     d.ack  = 1'b0;
                     d.busy = 1'b1;
                     d.st   = WRA_RDOFF;
                  end
               end else if (bk != 3'h0) begin
                  if (i_sub == `WRA_SUB_COUNT) begin
                     d.err   = i_wr;
                     d.rdata = 64'(`WRA_BANK_CNT); // [RULE5]
                  end else if (i_sub > `WRA_BANK_CNT) begin
                     d.err = 1'b1;
                  end else begin
                     d.ack  = 1'b0;
                     d.busy = 1'b1;
                     d.st   = WRA_LOOK;
                  end
               end else if (i_index == `WRA_IDX_SIZE) begin
                  d.err = i_wr; // All size entries are read-only
                  case (i_sub)
                     `WRA_SUB_COUNT: begin
                        d.rdata = 64'(`WRA_SIZE_CNT); // [RULE12]
                     end
                     `WRA_SUB_RX_REQ: begin
                        d.rdata = sext(i_rx_req_size); // [RULE10]
                     end
                     `WRA_SUB_RX_MAX: begin
                        d.rdata = 64'(`WRA_RX_MAX_SIZE); // [RULE12]
                     end
                     `WRA_SUB_TX_REQ: begin
                        d.rdata = sext(i_tx_req_size); // [RULE11]
                     end
                     `WRA_SUB_TX_MAX: begin
                        d.rdata = 64'(`WRA_TX_MAX_SIZE); // [RULE12]
                     end
                     default: begin
                        d.err = 1'b1;
                     end
                  endcase
                  if (i_wr) begin
                     d.rdata = q.rdata; // Write answers keep the last read
                  end
               end else begin
                  d.err = 1'b1; // Unknown object
               end
            end
         end
         // Offset read: the stored word is out of its register now
         WRA_RDOFF: begin
            d.rdata = sext(mem_rdata); // [RULE3]
            d.ack   = 1'b1;
            d.busy  = 1'b0;
            d.st    = WRA_IDLE;
         end
         // Lookup: offset of this bank is ready, form the register
         // number and raise the controller request
         WRA_LOOK: begin
            d.ctl_regnum = sum; // [RULE1] [RULE9] [RULE14]
            d.ctl_dbl    = q.bank >= `WRA_FIRST_DBL; // [RULE2]
            d.ctl_wr     = q.wr; // [RULE8]
            d.ctl_req    = 1'b1; // [RULE8]
            if (q.bank >= `WRA_FIRST_DBL) begin
               d.ctl_wdata = q.wdata; // [RULE7]
            end else begin
               d.ctl_wdata = sext(q.wdata[31:0]); // [RULE6]
            end
            d.st = WRA_CTL;
         end
         // Controller access: hold every request field until the
         // acknowledge, then answer the master
         WRA_CTL: begin
            if (i_ctl_ack) begin
               d.ctl_req = 1'b0;
               d.ack     = 1'b1;
               d.busy    = 1'b0;
               d.st      = WRA_IDLE;
               if (!q.wr && q.ctl_dbl) begin
                  d.rdata = i_ctl_rdata; // [RULE7]
               end else if (!q.wr) begin
                  d.rdata = sext(i_ctl_rdata[31:0]); // [RULE6]
               end
            end
         end
         default: begin
            d.st = WRA_IDLE;
         end
      endcase
   end

   // State register; synchroniser stage has the raw reset only
   // While the internal reset is low everything but the synchroniser
   // stays cleared, so no output moves before the release
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else if (!nrst_int) begin
         q          <= '0;
         q.rst_sync <= d.rst_sync;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign o_busy       = q.busy;
   assign o_ack        = q.ack;
   assign o_err        = q.err;
   assign o_rdata      = q.rdata;
   assign o_ctl_req    = q.ctl_req;
   assign o_ctl_wr     = q.ctl_wr;
   assign o_ctl_dbl    = q.ctl_dbl;
   assign o_ctl_regnum = REG_NUM_W'(q.ctl_regnum);
   assign o_ctl_wdata  = q.ctl_wdata;

endmodule : wra_top

// *** pkg/wra_pkg.sv ***
// Types shared by the windowed register access block
// Assumes nothing beyond the compile order of package before modules
package wra_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      WRA_IDLE,
      WRA_RDOFF,
      WRA_LOOK,
      WRA_CTL
   } wra_state_t;

   // Complete state of the top module
   typedef struct packed {
      logic [1:0]  rst_sync;
      wra_state_t  st;
      logic        busy;
      logic        ack;
      logic        err;
      logic [63:0] rdata;
      logic        wr;
      logic [7:0]  sub;
      logic [2:0]  bank;
      logic [63:0] wdata;
      logic        ctl_req;
      logic        ctl_wr;
      logic        ctl_dbl;
      logic [31:0] ctl_regnum;
      logic [63:0] ctl_wdata;
   } wra_state_s_t;

endpackage : wra_pkg

// *** pkg/wra_regs.svh ***
// Object indexes, entry counts and fixed values of the windowed access block
// Assumes inclusion from package or module scope, definitions only
`ifndef WRA_REGS_SVH
`define WRA_REGS_SVH

// Object indexes
`define WRA_IDX_OFFSET   16'h2000
`define WRA_IDX_BANK1    16'h2001
`define WRA_IDX_BANK5    16'h2005
`define WRA_IDX_SIZE     16'h2100

// Entry-count subindex and counts reported there
`define WRA_SUB_COUNT    8'h00
`define WRA_OFFSET_CNT   8'h05
`define WRA_BANK_CNT     8'h10
`define WRA_SIZE_CNT     8'h04

// Size object subindexes
`define WRA_SUB_RX_REQ   8'h01
`define WRA_SUB_RX_MAX   8'h02
`define WRA_SUB_TX_REQ   8'h03
`define WRA_SUB_TX_MAX   8'h04

// Fixed maximum image sizes
`define WRA_RX_MAX_SIZE  32'h0000_0400
`define WRA_TX_MAX_SIZE  32'h0000_0400

// First double bank, reset value of offsets
`define WRA_FIRST_DBL    3'h4
`define WRA_OFFSET_RST   32'h0000_0000

`endif

// *** verification/wra_ctl_model.sv ***
// Controller register store answering the block's register port
// Assumes the request level holds until the acknowledge is sampled
`timescale 1ns/1ps

module wra_ctl_model (
   input  wire logic        i_clk,
   input  wire logic        i_req,
   input  wire logic        i_wr,
   input  wire logic [31:0] i_regnum,
   input  wire logic [63:0] i_wdata,
   input  wire logic [3:0]  i_delay,
   output logic             o_ack,
   output logic [63:0]      o_rdata
);
   logic [63:0] mem [int unsigned];
   int          cnt = 0;
   initial o_ack = 1'b0;
   initial o_rdata = 64'h0;
   // Wait the delay, then answer once; data toggles when not valid
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (cnt >= i_delay) begin
            cnt = 0;
            o_ack <= 1'b1;
            if (i_wr) mem[i_regnum] = i_wdata;
            else o_rdata <= mem.exists(i_regnum) ? mem[i_regnum] : 64'h0;
         end else cnt++;
      end
   end
endmodule : wra_ctl_model

// *** verification/wra_top_assertions.sv ***
// Checker for the windowed access block, bound to its top module
// Assumes requests keep the hand-over timing, one at a time
`timescale 1ns/1ps
`include "wra_regs.svh"

module wra_top_assertions #(
   parameter int REG_NUM_W = 32
) (
   input wire logic                 i_clk,
   input wire logic                 i_nrst,
   input wire logic                 i_req,
   input wire logic                 i_wr,
   input wire logic [15:0]          i_index,
   input wire logic [7:0]           i_sub,
   input wire logic                 o_busy,
   input wire logic                 o_ack,
   input wire logic                 o_err,
   input wire logic [63:0]          o_rdata,
   input wire logic                 o_ctl_req,
   input wire logic                 o_ctl_wr,
   input wire logic                 o_ctl_dbl,
   input wire logic [REG_NUM_W-1:0] o_ctl_regnum,
   input wire logic [63:0]          o_ctl_wdata,
   input wire logic                 i_ctl_ack,
   input wire logic [31:0]          i_rx_req_size,
   input wire logic [31:0]          i_tx_req_size
);
   logic tk, tr, sz, bk;
   // Taken request, read, size object, bank object
   assign tk = i_req && !o_busy;
   assign tr = tk && !i_wr;
   assign sz = i_index == `WRA_IDX_SIZE;
   assign bk = i_index >= `WRA_IDX_BANK1 && i_index <= `WRA_IDX_BANK5;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   AST_SZ_RX: assert property (tr && sz && i_sub == 8'h01 |=>
      o_ack &&
      o_rdata == {{32{$past(i_rx_req_size[31])}}, $past(i_rx_req_size)})
      else $error("receive size wrong");
   AST_SZ_TX: assert property (tr && sz && i_sub == 8'h03 |=>
      o_ack &&
      o_rdata == {{32{$past(i_tx_req_size[31])}}, $past(i_tx_req_size)})
      else $error("transmit size wrong");
   AST_SZ_MAX: assert property (tr && sz && i_sub[0] == 1'b0 &&
      i_sub != 8'h00 && i_sub <= 8'h04 |=> o_rdata == 64'h400 && !o_err)
      else $error("maximum size wrong");
   AST_SZ_RO: assert property (tk && i_wr && sz |=>
      o_ack && o_err) else $error("size write not refused");
   AST_OFF_CNT: assert property (
      tr && i_index == `WRA_IDX_OFFSET && i_sub == 8'h00 |=>
      o_ack && o_rdata == 64'h5) else $error("offset count");
   AST_BK_CNT: assert property (tr && bk && i_sub == 8'h00 |=>
      o_ack && o_rdata == 64'h10 && !o_err) else $error("bank count wrong");
   AST_BK_RANGE: assert property (tk && bk && i_sub > 8'h10 |=>
      o_ack && o_err) else $error("bank subindex not refused");
   AST_BK_START: assert property (tk && bk && i_sub != 8'h00 &&
      i_sub <= 8'h10 |-> ##2 o_ctl_req && o_ctl_wr == $past(i_wr, 2) &&
      o_ctl_dbl == ($past(i_index, 2) >= 16'h2004)) else $error("bank start");
   AST_CTL_HOLD: assert property (o_ctl_req && !i_ctl_ack |=>
      o_ctl_req && $stable(o_ctl_regnum) && $stable(o_ctl_wdata))
      else $error("ctl moved");
   AST_CTL_DONE: assert property (o_ctl_req && i_ctl_ack |=>
      o_ack && !o_ctl_req && !o_busy) else $error("ctl answer missing");
   AST_INT_SEXT: assert property (
      o_ctl_req && o_ctl_wr && !o_ctl_dbl |->
      o_ctl_wdata[63:32] == {32{o_ctl_wdata[31]}}) else $error("no sign ext");
endmodule : wra_top_assertions

bind wra_top wra_top_assertions #(.REG_NUM_W(REG_NUM_W))
   u_wra_top_assertions (
   .i_clk, .i_nrst, .i_req, .i_wr, .i_index, .i_sub, .o_busy, .o_ack, .o_err,
   .o_rdata, .o_ctl_req, .o_ctl_wr, .o_ctl_dbl, .o_ctl_regnum, .o_ctl_wdata,
   .i_ctl_ack, .i_rx_req_size, .i_tx_req_size);

// *** verification/wra_top_tb.sv ***
// Bench for the windowed access block with a controller model behind it
// Assumes package, register header and checker are compiled first
`timescale 1ns/1ps
`include "wra_regs.svh"
`define CHK(a, b) num_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end

module wra_top_tb;
   import wra_pkg::*;
   logic        i_clk = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_wr = 1'b0;
   logic [15:0] i_index = 16'h0;
   logic [7:0]  i_sub = 8'h0;
   logic [63:0] i_wdata = 64'h0;
   logic [31:0] i_rx_req_size = 32'h0, i_tx_req_size = 32'h0;
   logic [3:0]  slow = 4'h0;
   logic        o_busy, o_ack, o_err, o_ctl_req, o_ctl_wr, o_ctl_dbl;
   logic        i_ctl_ack, er, db;
   logic [31:0] o_ctl_regnum, rn, ov;
   logic [63:0] o_rdata, o_ctl_wdata, i_ctl_rdata, rd, cw;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   localparam logic [63:0] PI = 64'h4009_21FB_5444_2D18;

   // Clock, and a ceiling on the run length
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         finish_test();
      end
   end

   wra_top u_wra_top (.i_clk, .i_nrst, .i_req, .i_wr, .i_index, .i_sub,
      .i_wdata, .o_busy, .o_ack, .o_err, .o_rdata, .o_ctl_req, .o_ctl_wr,
      .o_ctl_dbl, .o_ctl_regnum, .o_ctl_wdata, .i_ctl_ack, .i_ctl_rdata,
      .i_rx_req_size, .i_tx_req_size);
   wra_ctl_model u_wra_ctl_model (.i_clk, .i_req(o_ctl_req), .i_wr(o_ctl_wr),
      .i_regnum(o_ctl_regnum), .i_wdata(o_ctl_wdata), .i_delay(slow),
      .o_ack(i_ctl_ack), .o_rdata(i_ctl_rdata));

   function automatic logic [63:0] sx(input logic [31:0] v);
      return {{32{v[31]}}, v};
   endfunction : sx

   // One object request; waits for the answer, keeps the ctl fields seen
   task automatic xfer(input logic w, input logic [15:0] ix,
                       input logic [7:0] s, input logic [63:0] d);
      int n;
      @(negedge i_clk);
      {i_req, i_wr, i_index, i_sub, i_wdata} = {1'b1, w, ix, s, d};
      @(negedge i_clk);
      i_req = 1'b0;
      n = 0;
      while (o_ack !== 1'b1 && n < 40) begin
         if (o_ctl_req === 1'b1) begin
            {rn, db, cw} = {o_ctl_regnum, o_ctl_dbl, o_ctl_wdata};
         end
         @(negedge i_clk);
         n++;
      end
      {er, rd} = {o_err, o_rdata};
      `CHK(o_ack, 1'b1)
   endtask : xfer

   // Offsets read zero after reset, count is five and read-only
   task automatic t_reset;
      for (int n = 1; n <= 5; n++) begin
         xfer(1'b0, `WRA_IDX_OFFSET, n[7:0], 64'h0);
         `CHK(rd, 64'h0)
      end
      xfer(1'b0, `WRA_IDX_OFFSET, 8'h00, 64'h0);
      `CHK(rd, 64'h5)
      xfer(1'b1, `WRA_IDX_OFFSET, 8'h00, 64'h9);
      `CHK(er, 1'b1)
   endtask : t_reset

   // Each bank resolves with its own offset, width by bank kind
   task automatic t_offsets;
      for (int n = 1; n <= 5; n++) begin
         ov = (n == 4) ? 32'hFFFF_FFFD : 32'(n * 256);
         xfer(1'b1, `WRA_IDX_OFFSET, n[7:0], {32'h0, ov});
         xfer(1'b0, `WRA_IDX_OFFSET, n[7:0], 64'h0);
         `CHK(rd, sx(ov))
         slow = 4'(n * 2);
         xfer(1'b0, 16'h2000 + n[15:0], 8'h10, 64'h0);
         `CHK(rn, ov + 32'h10)
         `CHK(db, n >= 4)
      end
   endtask : t_offsets

   // Writes reach the register and read back, integer sign-extended
   task automatic t_data;
      xfer(1'b1, `WRA_IDX_BANK1, 8'h03, 64'h1234_5678_FFFF_FFF9);
      `CHK(cw, sx(32'hFFFF_FFF9))
      xfer(1'b0, `WRA_IDX_BANK1, 8'h03, 64'h0);
      `CHK(rd, sx(32'hFFFF_FFF9))
      slow = 4'h0;
      xfer(1'b1, 16'h2004, 8'h10, PI);
      `CHK(cw, PI)
      xfer(1'b0, 16'h2004, 8'h10, 64'h0);
      `CHK(rd, PI)
   endtask : t_data

   // A new offset reaches far registers on the very next access
   task automatic t_wide;
      xfer(1'b1, `WRA_IDX_OFFSET, 8'h01, 64'h8CA0);
      xfer(1'b0, `WRA_IDX_BANK1, 8'h01, 64'h0);
      `CHK(rn, 32'h8CA1)
   endtask : t_wide

   // Bank counts and limits, size object values and refusal
   task automatic t_sizes;
      xfer(1'b0, `WRA_IDX_BANK5, 8'h00, 64'h0);
      `CHK(rd, 64'h10)
      xfer(1'b0, 16'h2002, 8'h11, 64'h0);
      `CHK(er, 1'b1)
      {i_rx_req_size, i_tx_req_size} = {32'h40, 32'h88};
      xfer(1'b0, `WRA_IDX_SIZE, 8'h01, 64'h0);
      `CHK(rd, 64'h40)
      xfer(1'b0, `WRA_IDX_SIZE, 8'h03, 64'h0);
      `CHK(rd, 64'h88)
      for (int s = 0; s <= 4; s += 2) begin
         xfer(1'b0, `WRA_IDX_SIZE, s[7:0], 64'h0);
         `CHK(rd, (s == 0) ? 64'h4 : 64'h400)
      end
      xfer(1'b1, `WRA_IDX_SIZE, 8'h01, 64'h5);
      `CHK(er, 1'b1)
   endtask : t_sizes

   task automatic finish_test;
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // Reset, then the scenarios in turn
   initial begin
      repeat (10) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (4) @(negedge i_clk);
      t_reset();
      t_offsets();
      t_data();
      t_wide();
      t_sizes();
      finish_test();
   end
endmodule : wra_top_tb
